// >>> common/ppcd_params.svh
// Constants for the power port capability descriptor source.
// Assumes inclusion by bare name from every file that needs them.
`ifndef PPCD_PARAMS_SVH
`define PPCD_PARAMS_SVH

// Header bytes
`define PPCD_OFS_LENGTH     8'h00
`define PPCD_OFS_DTYPE      8'h01
`define PPCD_OFS_CODE       8'h02
`define PPCD_OFS_RSVD0      8'h03
`define PPCD_OFS_BITMAP     8'h04
// Sink descriptor fields
`define PPCD_OFS_MIN_V      8'h06
`define PPCD_OFS_MAX_V      8'h08
`define PPCD_OFS_RSVD1      8'h0A
`define PPCD_OFS_STEADY     8'h0C
`define PPCD_OFS_PEAK       8'h10
`define PPCD_OFS_DUR        8'h14
`define PPCD_SINK_LENGTH    8'h18
// Source descriptor fields
`define PPCD_OFS_COUNT      8'h06
`define PPCD_OFS_RSVD2      8'h07
`define PPCD_OFS_PDO        8'h08
`define PPCD_SRC_HDR_LENGTH 8'h08
`define PPCD_PDO_BYTES      8'h04
// Bitmap layout
`define PPCD_BITMAP_USED    3
`define PPCD_BITMAP_PAD     13
// Values
`define PPCD_DUR_UNKNOWN    32'h0000FFFF
`define PPCD_DEVCAP_TYPE    8'h10
`define PPCD_SINK_CODE      8'h01
`define PPCD_SOURCE_CODE    8'h02
`define PPCD_MAX_PDO        7
`define PPCD_ZERO_BYTE      8'h00

`endif

// >>> common/ppcd_pkg.sv
// Types shared by the descriptor source and its power object store.
// Assumes ppcd_params.svh is on the include path.
`default_nettype none
package ppcd_pkg;

    // Which descriptor a read addresses
    typedef enum logic [0:0]
    {
        PPCD_SINK   = 1'b0,
        PPCD_SOURCE = 1'b1
    } ppcd_desc_type;

    // Whole state of the top module
    typedef struct packed
    {
        logic        sink_en;
        logic        source_en;
        logic [15:0] sink_bitmap;
        logic [15:0] min_v;
        logic [15:0] max_v;
        logic [31:0] steady;
        logic [31:0] peak;
        logic [31:0] dur;
        logic [15:0] src_bitmap;
        logic [7:0]  pdo_count;
        logic [7:0]  src_len;
        logic        rd_valid;
        logic        rd_absent;
        logic [7:0]  rd_data;
    } ppcd_state_type;

endpackage
`default_nettype wire

// >>> src/ppcd_pdo_store.sv
// Storage for the source port's power data objects, byte readout.
// Assumes writes and reads come from logic on the same clock.
`default_nettype none
`include "ppcd_params.svh"
module ppcd_pdo_store
    import ppcd_pkg::*;
#(
    parameter int MAX_PDO = `PPCD_MAX_PDO
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wr,
    input  wire logic [2:0]  wr_idx,
    input  wire logic [31:0] wr_data,
    input  wire logic [7:0]  rd_rel,
    output logic      [7:0]  rd_byte
);

    // Local state: one word per power data object
    typedef struct packed
    {
        logic [MAX_PDO-1:0][31:0] pdo;
    } ppcd_store_type;

    ppcd_store_type st_q;
    ppcd_store_type st_d;
    logic [5:0]     obj;

    // Write port, out-of-range index ignored
    always_comb
    begin
        st_d = st_q;
        if (wr && (int'(wr_idx) < MAX_PDO))
        begin
            st_d.pdo[wr_idx] = wr_data;
        end
    end

    // Byte select, low byte of each object first
    always_comb
    begin
        obj = rd_rel[7:2];
        rd_byte = `PPCD_ZERO_BYTE;
        if (int'(obj) < MAX_PDO)
        begin
            rd_byte = st_q.pdo[obj[2:0]][8*rd_rel[1:0] +: 8];
        end
    end

    // Cleared by device reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

endmodule
`default_nettype wire

// >>> src/ppcd_top.sv
// Sink and source port capability descriptors, read a byte at a time.
// Assumes configuration inputs come from logic on CLK_SYS.
`default_nettype none
`include "ppcd_params.svh"
module ppcd_top
    import ppcd_pkg::*;
#(
    // Store depth, then type and capability codes (codes arbitrary)
    parameter int         MAX_PDO     = `PPCD_MAX_PDO,
    parameter logic [7:0] DEVCAP_TYPE = `PPCD_DEVCAP_TYPE,
    parameter logic [7:0] SINK_CODE   = `PPCD_SINK_CODE,
    parameter logic [7:0] SOURCE_CODE = `PPCD_SOURCE_CODE
)
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // Configuration of the two descriptors
    input  wire logic        SINK_EN,
    input  wire logic        SOURCE_EN,
    input  wire logic [2:0]  SINK_SPEC_BITS,
    input  wire logic [15:0] LOWEST_OPERATING_VOLTAGE,
    input  wire logic [15:0] HIGHEST_OPERATING_VOLTAGE,
    input  wire logic [31:0] STEADY_POWER_LIMIT,
    input  wire logic [31:0] PEAK_POWER_LIMIT,
    input  wire logic [31:0] PEAK_DURATION_LIMIT,
    input  wire logic        PEAK_DURATION_KNOWN,
    input  wire logic [2:0]  SOURCE_SPEC_BITS,
    input  wire logic [7:0]  POWER_OBJECT_COUNT,
    // Power data object writes
    input  wire logic        PDO_WR,
    input  wire logic [2:0]  PDO_WR_IDX,
    input  wire logic [31:0] PDO_WR_DATA,
    // Descriptor read port
    input  wire logic        RD_REQ,
    input  wire logic        RD_SEL,
    input  wire logic [7:0]  RD_ADDR,
    output logic             RD_VALID,
    output logic      [7:0]  RD_DATA,
    output logic             RD_ABSENT,
    // Derived source fields
    output logic      [7:0]  SOURCE_LENGTH,
    output logic      [7:0]  SOURCE_OBJECT_COUNT
);

    // Store depth as a byte, for the count clamp
    localparam logic [7:0] MAX_PDO_B = 8'(MAX_PDO);

    // State, store readout, clamped count and answer candidates
    ppcd_state_type s_q;
    ppcd_state_type s_d;
    logic [7:0]     pdo_rel;
    logic [7:0]     pdo_byte;
    logic [7:0]     cnt_c;
    ppcd_desc_type  sel_c;
    logic [7:0]     sink_b;
    logic [7:0]     source_b;

    // Offset into the object area of the source descriptor
    assign pdo_rel = RD_ADDR - `PPCD_OFS_PDO;

    // Power data object storage
    ppcd_pdo_store
    #(
        .MAX_PDO (MAX_PDO)
    )
    u_store
    (
        .clk     (CLK_SYS),
        .rst_n   (RST_N),
        .wr      (PDO_WR),
        .wr_idx  (PDO_WR_IDX),
        .wr_data (PDO_WR_DATA),
        .rd_rel  (pdo_rel),
        .rd_byte (pdo_byte)
    );

    // Byte of a 16-bit field, low byte first
    function automatic logic [7:0] half_byte
    (
        input logic [15:0] v,
        input logic [7:0]  rel
    );
        half_byte = v[8*rel[0] +: 8];
    endfunction

    // Byte of a 32-bit field, low byte first
    function automatic logic [7:0] word_byte
    (
        input logic [31:0] v,
        input logic [7:0]  rel
    );
        word_byte = v[8*rel[1:0] +: 8];
    endfunction

    // Sink descriptor byte at a given offset
    function automatic logic [7:0] sink_byte
    (
        input ppcd_state_type s,
        input logic [7:0]     a
    );
        logic [7:0] r;
        r = `PPCD_ZERO_BYTE;
        // Common header bytes
        if (a == `PPCD_OFS_LENGTH)
        begin
            r = `PPCD_SINK_LENGTH;
        end
        else if (a == `PPCD_OFS_DTYPE)
        begin
            r = DEVCAP_TYPE;
        end
        else if (a == `PPCD_OFS_CODE)
        begin
            r = SINK_CODE;
        end
        else if (a == `PPCD_OFS_RSVD0)
        begin
            r = `PPCD_ZERO_BYTE;
        end
        // Bitmap and voltage fields
        else if (a < `PPCD_OFS_MIN_V)
        begin
            r = half_byte(s.sink_bitmap, a - `PPCD_OFS_BITMAP);
        end
        else if (a < `PPCD_OFS_MAX_V)
        begin
            r = half_byte(s.min_v, a - `PPCD_OFS_MIN_V);
        end
        else if (a < `PPCD_OFS_RSVD1)
        begin
            r = half_byte(s.max_v, a - `PPCD_OFS_MAX_V);
        end
        // Reserved 16-bit field, then power and duration fields
        else if (a < `PPCD_OFS_STEADY)
        begin
            r = `PPCD_ZERO_BYTE;
        end
        else if (a < `PPCD_OFS_PEAK)
        begin
            r = word_byte(s.steady, a - `PPCD_OFS_STEADY);
        end
        else if (a < `PPCD_OFS_DUR)
        begin
            r = word_byte(s.peak, a - `PPCD_OFS_PEAK);
        end
        else if (a < `PPCD_SINK_LENGTH)
        begin
            r = word_byte(s.dur, a - `PPCD_OFS_DUR);
        end
        else
        begin
            r = `PPCD_ZERO_BYTE; // Past the end reads zero
        end
        sink_byte = r;
    endfunction

    // Source descriptor byte; the object area comes from the store
    function automatic logic [7:0] source_byte
    (
        input ppcd_state_type s,
        input logic [7:0]     a,
        input logic [7:0]     obj_b
    );
        logic [7:0] r;
        r = `PPCD_ZERO_BYTE;
        // Common header bytes
        if (a == `PPCD_OFS_LENGTH)
        begin
            r = s.src_len;
        end
        else if (a == `PPCD_OFS_DTYPE)
        begin
            r = DEVCAP_TYPE;
        end
        else if (a == `PPCD_OFS_CODE)
        begin
            r = SOURCE_CODE;
        end
        else if (a == `PPCD_OFS_RSVD0)
        begin
            r = `PPCD_ZERO_BYTE;
        end
        // Bitmap, object count and the objects
        else if (a < `PPCD_OFS_COUNT)
        begin
            r = half_byte(s.src_bitmap, a - `PPCD_OFS_BITMAP);
        end
        else if (a == `PPCD_OFS_COUNT)
        begin
            r = s.pdo_count;
        end
        else if (a == `PPCD_OFS_RSVD2)
        begin
            r = `PPCD_ZERO_BYTE;
        end
        else if (a < s.src_len)
        begin
            r = obj_b;
        end
        else
        begin
            r = `PPCD_ZERO_BYTE; // Past the end reads zero
        end
        source_byte = r;
    endfunction

    // Selected descriptor and the candidate byte of each
    assign sel_c    = ppcd_desc_type'(RD_SEL);
    assign sink_b   = sink_byte(s_q, RD_ADDR);
    assign source_b = source_byte(s_q, RD_ADDR, pdo_byte);

    // Configuration capture and read answer
    always_comb
    begin
        s_d = s_q;

        // Object count clamped to the store depth
        if (POWER_OBJECT_COUNT > MAX_PDO_B)
        begin
            cnt_c = MAX_PDO_B;
        end
        else
        begin
            cnt_c = POWER_OBJECT_COUNT;
        end

        // Which descriptors are offered
        s_d.sink_en   = SINK_EN;
        s_d.source_en = SOURCE_EN;

        // Spec bitmaps, reserved upper bits forced low
        s_d.sink_bitmap =
            {{`PPCD_BITMAP_PAD{1'b0}}, SINK_SPEC_BITS};
        s_d.src_bitmap =
            {{`PPCD_BITMAP_PAD{1'b0}}, SOURCE_SPEC_BITS};

        // Voltage and power limits of the sink
        s_d.min_v  = LOWEST_OPERATING_VOLTAGE;
        s_d.max_v  = HIGHEST_OPERATING_VOLTAGE;
        s_d.steady = STEADY_POWER_LIMIT;
        s_d.peak   = PEAK_POWER_LIMIT;

        // Peak duration, all ones in the low half when unknown
        if (PEAK_DURATION_KNOWN)
        begin
            s_d.dur = PEAK_DURATION_LIMIT;
        end
        else
        begin
            s_d.dur = `PPCD_DUR_UNKNOWN;
        end

        // Source object count and the length that follows from it
        s_d.pdo_count = cnt_c;
        s_d.src_len = `PPCD_SRC_HDR_LENGTH
                    + 8'(cnt_c * `PPCD_PDO_BYTES);

        // Read answer one cycle after the request, data held otherwise
        s_d.rd_valid = RD_REQ;
        if (RD_REQ)
        begin
            if (sel_c == PPCD_SINK)
            begin
                s_d.rd_absent = !s_q.sink_en;
                s_d.rd_data   = `PPCD_ZERO_BYTE;
                if (s_q.sink_en)
                begin
                    s_d.rd_data = sink_b;
                end
            end
            else
            begin
                s_d.rd_absent = !s_q.source_en;
                s_d.rd_data   = `PPCD_ZERO_BYTE;
                if (s_q.source_en)
                begin
                    s_d.rd_data = source_b;
                end
            end
        end
    end

    // Single state register, cleared by device reset
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign RD_VALID            = s_q.rd_valid;
    assign RD_DATA             = s_q.rd_data;
    assign RD_ABSENT           = s_q.rd_absent;
    assign SOURCE_LENGTH       = s_q.src_len;
    assign SOURCE_OBJECT_COUNT = s_q.pdo_count;

endmodule
`default_nettype wire

// >>> sim/ppcd_chk.sv
// Assertions on the descriptor read port and length outputs.
// Assumes it is bound to ppcd_top and sees only its ports.
`default_nettype none
module ppcd_chk
(
    input wire logic       CLK_SYS,
    input wire logic       RST_N,
    input wire logic       SINK_EN,
    input wire logic       SOURCE_EN,
    input wire logic       PEAK_DURATION_KNOWN,
    input wire logic [7:0] POWER_OBJECT_COUNT,
    input wire logic       RD_REQ,
    input wire logic       RD_SEL,
    input wire logic [7:0] RD_ADDR,
    input wire logic       RD_VALID,
    input wire logic [7:0] RD_DATA,
    input wire logic       RD_ABSENT,
    input wire logic [7:0] SOURCE_LENGTH,
    input wire logic [7:0] SOURCE_OBJECT_COUNT
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    // Read answer timing
    chk_valid_follows:
        assert property (RD_REQ |=> RD_VALID) else $error("no answer");
    chk_valid_single:
        assert property (!RD_REQ |=> !RD_VALID) else $error("stray answer");
    // Sink contents
    chk_sink_length:
        assert property (RD_REQ && !RD_SEL && RD_ADDR == 8'h00
            && $past(SINK_EN) |=> RD_DATA == 8'h18 && !RD_ABSENT)
        else $error("sink length wrong");
    chk_rsvd_zero:
        assert property (RD_REQ && !RD_SEL && $past(SINK_EN)
            && RD_ADDR inside {8'h03, 8'h05, 8'h0A, 8'h0B}
            |=> RD_DATA == 8'h00) else $error("reserved byte set");
    chk_dur_unknown:
        assert property (RD_REQ && !RD_SEL && $past(SINK_EN)
            && !$past(PEAK_DURATION_KNOWN)
            && RD_ADDR inside {8'h14, 8'h15} |=> RD_DATA == 8'hFF)
        else $error("unknown duration wrong");
    // Absent descriptors
    chk_absent_data:
        assert property (RD_VALID && RD_ABSENT |-> RD_DATA == 8'h00)
        else $error("absent data nonzero");
    chk_src_absent:
        assert property (RD_REQ && RD_SEL && !$past(SOURCE_EN)
            |=> RD_ABSENT) else $error("source not absent");
    // Source length and count
    chk_src_length:
        assert property (POWER_OBJECT_COUNT < 8'h08 |=> SOURCE_LENGTH ==
            8'h08 + {$past(POWER_OBJECT_COUNT[5:0]), 2'b00})
        else $error("source length wrong");
    chk_count_clamp:
        assert property (POWER_OBJECT_COUNT > 8'h07
            |=> SOURCE_OBJECT_COUNT == 8'h07) else $error("no clamp");
endmodule
bind ppcd_top ppcd_chk chk_u (.CLK_SYS, .RST_N, .SINK_EN, .SOURCE_EN,
    .PEAK_DURATION_KNOWN, .POWER_OBJECT_COUNT, .RD_REQ, .RD_SEL, .RD_ADDR,
    .RD_VALID, .RD_DATA, .RD_ABSENT, .SOURCE_LENGTH, .SOURCE_OBJECT_COUNT);
`default_nettype wire

// >>> sim/ppcd_host.sv
// Host side reader: one descriptor byte per call.
// Assumes the caller shares the design clock.
`default_nettype none
module ppcd_host
(
    input  wire logic       clk,
    input  wire logic       valid,
    input  wire logic [7:0] data,
    input  wire logic       absent,
    output logic            req,
    output logic            sel,
    output logic      [7:0] addr
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle values at time zero
    initial
    begin
        req = 1'b0;
        sel = 1'b0;
        addr = 8'h00;
    end

    // Request driven after one edge, taken and answered at the next
    task automatic rd(input logic s, input logic [7:0] a,
                      output logic v, output logic [7:0] d, output logic b);
        @(posedge clk);
        #1;
        req = 1'b1;
        sel = s;
        addr = a;
        @(posedge clk);
        #1;
        v = valid;
        d = data;
        b = absent;
        req = 1'b0;
        sel = ~s;
        addr = ~a;
    endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the descriptor source.
// Assumes the host model and the bound checker are compiled with it.
`default_nettype none
`include "ppcd_params.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
    miscompares++; $display("CHECK FAILED %0t mismatch", $time); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst_n, sink_en, source_en, dur_known, pdo_wr;
    logic        rd_req, rd_sel, rd_valid, rd_absent;
    logic [2:0]  sink_bits, src_bits, pdo_idx;
    logic [7:0]  obj_cnt, rd_addr, rd_data, src_len, src_cnt;
    logic [15:0] lo_v, hi_v;
    logic [31:0] steady, peak, dur, pdo_data;
    logic [31:0] pdo [8];
    int          miscompares, tests_run;

    ppcd_top dut_u (.CLK_SYS(clk), .RST_N(rst_n), .SINK_EN(sink_en),
        .SOURCE_EN(source_en), .SINK_SPEC_BITS(sink_bits),
        .LOWEST_OPERATING_VOLTAGE(lo_v), .HIGHEST_OPERATING_VOLTAGE(hi_v),
        .STEADY_POWER_LIMIT(steady), .PEAK_POWER_LIMIT(peak),
        .PEAK_DURATION_LIMIT(dur), .PEAK_DURATION_KNOWN(dur_known),
        .SOURCE_SPEC_BITS(src_bits), .POWER_OBJECT_COUNT(obj_cnt),
        .PDO_WR(pdo_wr), .PDO_WR_IDX(pdo_idx), .PDO_WR_DATA(pdo_data),
        .RD_REQ(rd_req), .RD_SEL(rd_sel), .RD_ADDR(rd_addr),
        .RD_VALID(rd_valid), .RD_DATA(rd_data), .RD_ABSENT(rd_absent),
        .SOURCE_LENGTH(src_len), .SOURCE_OBJECT_COUNT(src_cnt));
    ppcd_host host_u (.clk(clk), .valid(rd_valid), .data(rd_data),
        .absent(rd_absent), .req(rd_req), .sel(rd_sel), .addr(rd_addr));

    // Verdict and end of run
    task automatic summarize();
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One byte read against an expectation
    task automatic rd_chk(input logic s, input logic [7:0] a,
                          input logic [7:0] e, input logic ab);
        logic       v, b;
        logic [7:0] d;
        host_u.rd(s, a, v, d, b);
        `CHK({v, b, d}, {1'b1, ab, e})
    endtask

    // Whole sink descriptor, byte by byte
    task automatic sink_pass();
        logic [191:0] x;
        x = {dur_known ? dur : `PPCD_DUR_UNKNOWN, peak, steady, 16'h0000,
             hi_v, lo_v, 13'h0000, sink_bits, 8'h00, `PPCD_SINK_CODE,
             `PPCD_DEVCAP_TYPE, 8'h18};
        for (int i = 0; i < 24; i++)
            rd_chk(1'b0, 8'(i), x[8*i+:8], 1'b0);
    endtask

    // Whole source descriptor plus four bytes past its end
    task automatic src_pass(input logic [7:0] c);
        logic [319:0] x;
        logic [7:0]   n, len;
        obj_cnt = c;
        n = (c > 8'h07) ? 8'h07 : c;
        len = 8'h08 + {n[5:0], 2'b00};
        x = '0;
        x[63:0] = {8'h00, n, 13'h0000, src_bits, 8'h00,
                   `PPCD_SOURCE_CODE, `PPCD_DEVCAP_TYPE, len};
        for (int j = 0; j < 7; j++)
            if (j < n)
                x[64+32*j+:32] = pdo[j];
        for (int i = 0; i < len + 4; i++)
            rd_chk(1'b1, 8'(i), x[8*i+:8], 1'b0);
        `CHK({src_len, src_cnt}, {len, n})
    endtask

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard
    initial
    begin
        repeat (30000) @(posedge clk);
        miscompares++;
        summarize();
    end

    // Main sequence
    initial
    begin
        {rst_n, pdo_wr, pdo_idx, pdo_data} = '0;
        {sink_en, source_en, dur_known} = 3'b111;
        {sink_bits, src_bits, obj_cnt} = {3'h5, 3'h3, 8'h00};
        {lo_v, hi_v} = {16'h0064, 16'h0190};
        {steady, peak, dur} = {32'h000001F4, 32'h12345678, 32'h0000000A};
        miscompares = 0;
        tests_run = 0;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        sink_pass();
        {dur_known, sink_bits, src_bits} = {1'b0, 3'h7, 3'h4};
        sink_pass();
        for (int j = 0; j < 8; j++)
        begin
            pdo[j] = 32'hA1B2C3D4 ^ {4{8'(j)}};
            @(posedge clk);
            #1 {pdo_wr, pdo_idx, pdo_data} = {1'b1, 3'(j), pdo[j]};
        end
        @(posedge clk);
        #1 pdo_wr = 1'b0;
        src_pass(8'h00);
        src_pass(8'h01);
        src_pass(8'h07);
        src_pass(8'h09);
        {sink_en, source_en} = 2'b00;
        rd_chk(1'b0, 8'h00, 8'h00, 1'b1);
        rd_chk(1'b1, 8'h06, 8'h00, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
